// ==== rtl/rtci_cfg.svh ====
// Purpose: numeric constants of the rtc two-wire register port
// Assumes: included by its bare name wherever a figure is needed
// Notes: timing counts derive from the 100 MHz system clock
`ifndef RTCI_CFG_SVH
`define RTCI_CFG_SVH

// slave address byte, write and read forms
`define RTCI_ADDR_W 8'hD0
`define RTCI_ADDR_R 8'hD1
// location map
`define RTCI_LOC_LAST 5'h13
`define RTCI_CLK_LOC_LAST 5'h07
`define RTCI_RSV_FIRST 5'h10
`define RTCI_RSV_LAST 5'h12
// timing: system clock period and generated bus clock period, in ns
`define RTCI_CLK_PERIOD_NS 10
`define RTCI_SCL_PERIOD_NS 2500
// a quarter of the bus clock period, least time so rounded up
`define RTCI_QTR_CYC (((`RTCI_SCL_PERIOD_NS / 4) + `RTCI_CLK_PERIOD_NS - 1) / `RTCI_CLK_PERIOD_NS)
// write data buffer in the master
`define RTCI_FIFO_WIDTH 8
`define RTCI_FIFO_DEPTH 4

`endif

// ==== rtl/rtci_pkg.sv ====
// Purpose: shared types of the rtc two-wire register port
// Assumes: nothing beyond the language
// Notes: state machines use one-hot codes
package rtci_pkg;

    // slave end states
    typedef enum logic [4:0] {
        D_IDLE  = 5'h01,
        D_ADDR  = 5'h02,
        D_PTR   = 5'h04,
        D_WDATA = 5'h08,
        D_RDATA = 5'h10
    } rtci_dev_state_type;

    // master end states
    typedef enum logic [5:0] {
        H_IDLE  = 6'h01,
        H_START = 6'h02,
        H_LOAD  = 6'h04,
        H_TXB   = 6'h08,
        H_RXB   = 6'h10,
        H_STOP  = 6'h20
    } rtci_host_state_type;

    // which byte the master is sending
    typedef enum logic [3:0] {
        G_AW   = 4'h1,
        G_PTR  = 4'h2,
        G_AR   = 4'h4,
        G_DATA = 4'h8
    } rtci_stage_type;

    // master commands
    typedef enum logic [1:0] {
        OP_WRITE    = 2'h0,
        OP_READ_PTR = 2'h1,
        OP_READ_CUR = 2'h2
    } rtci_op_type;

endpackage

// ==== rtl/rtci_bus_if.sv ====
// Purpose: two open-drain wires joining master and slave ends
// Assumes: both lines pulled up; an enabled driver with output 0 pulls low
// Notes: the line levels are resolved here, never inside the ends
`timescale 1ns/100ps
interface rtci_bus_if;
    logic host_scl_o;
    logic host_scl_oe;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic scl;
    logic sda;

    // wired-and with pull-ups
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport host(output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
    modport dev(output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// ==== rtl/rtci_dev.sv ====
// Purpose: slave end of the rtc two-wire port with twenty byte locations
// Assumes: bus pins come from outside the clock domain; no clock stretching
// Notes: the user side loads the time copy and sees writes and hold status
`timescale 1ns/100ps
`include "rtci_cfg.svh"

module rtci_dev
    import rtci_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    rtci_bus_if.dev bus,
    input wire logic tc_we_i,
    input wire logic [4:0] tc_addr_i,
    input wire logic [7:0] tc_data_i,
    output logic reg_wr_o,
    output logic [4:0] reg_addr_o,
    output logic [7:0] reg_data_o,
    output logic hold_update_o,
    output logic div_reset_o,
    output logic [4:0] ptr_o
);

    typedef struct packed {
        logic [2:0] scl_sy;
        logic [2:0] sda_sy;
        rtci_dev_state_type st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rd;
        logic mnak;
        logic [4:0] ptr;
        logic sda_low;
        logic hold;
        logic [19:0][7:0] mem;
        logic wr;
        logic [4:0] wa;
        logic [7:0] wd;
        logic divrst;
    } rtci_dev_reg_type;

    rtci_dev_reg_type r;
    rtci_dev_reg_type next_r;
    logic scl_rise;
    logic scl_fall;
    logic scl_high;
    logic sda_now;
    logic bus_start;
    logic bus_stop;

    // location is one of the eight timekeeping bytes
    function automatic logic is_clk(input logic [4:0] p);
        return p <= `RTCI_CLK_LOC_LAST;
    endfunction

    // location is reserved, reads zero and ignores writes
    function automatic logic is_rsv(input logic [4:0] p);
        return (p >= `RTCI_RSV_FIRST) && (p <= `RTCI_RSV_LAST);
    endfunction

    // location after p, wrapping at the last one
    function automatic logic [4:0] next_loc(input logic [4:0] p);
        return (p >= `RTCI_LOC_LAST) ? 5'h00 : 5'(p + 5'h01);
    endfunction

    // bus events, read only from the second and third synchroniser stages
    assign scl_rise = r.scl_sy[1] & ~r.scl_sy[2];
    assign scl_fall = ~r.scl_sy[1] & r.scl_sy[2];
    assign scl_high = r.scl_sy[1] & r.scl_sy[2];
    assign sda_now = r.sda_sy[1];
    assign bus_start = scl_high & r.sda_sy[2] & ~r.sda_sy[1];
    assign bus_stop = scl_high & ~r.sda_sy[2] & r.sda_sy[1];

    // next-state logic of the whole slave
    always_comb begin
        next_r = r;
        next_r.scl_sy = {r.scl_sy[1:0], bus.scl};
        next_r.sda_sy = {r.sda_sy[1:0], bus.sda};
        next_r.wr = 1'h0;
        next_r.divrst = 1'h0;
        // user copy update; refused while the bus holds a clock location
        if (tc_we_i && !r.hold && (tc_addr_i <= `RTCI_LOC_LAST) && !is_rsv(tc_addr_i)) begin
            next_r.mem[tc_addr_i] = tc_data_i;
        end
        if (bus_start) begin
            // a start, repeated or not, always restarts address reception
            next_r.st = D_ADDR;
            // the scl fall that closes the start wraps this to zero, so it is no bit
            next_r.bitn = 4'hF;
            next_r.sda_low = 1'h0;
        end else if (bus_stop) begin
            next_r.st = D_IDLE;
            next_r.sda_low = 1'h0;
            next_r.hold = 1'h0;
        end else begin
            case (r.st)
                D_ADDR, D_PTR, D_WDATA: begin
                    if (scl_rise && (r.bitn < 4'h8)) begin
                        next_r.sh = {r.sh[6:0], sda_now};
                    end
                    if (scl_fall) begin
                        if (r.bitn == 4'h7) begin
                            // eighth bit taken: decide the acknowledge
                            next_r.bitn = 4'h8;
                            if ((r.st != D_ADDR) || (r.sh[7:1] == 7'(`RTCI_ADDR_W >> 1))) begin
                                next_r.sda_low = 1'h1;
                                if (r.st == D_ADDR) begin
                                    next_r.rd = r.sh[0];
                                end
                            end else begin
                                next_r.st = D_IDLE;
                            end
                        end else if (r.bitn == 4'h8) begin
                            // acknowledge pulse over: release and act on the byte
                            next_r.bitn = 4'h0;
                            next_r.sda_low = 1'h0;
                            case (r.st)
                                D_ADDR: begin
                                    next_r.hold = is_clk(r.ptr);
                                    if (r.rd) begin
                                        // read straight from the held pointer
                                        next_r.st = D_RDATA;
                                        next_r.sh = r.mem[r.ptr];
                                        next_r.sda_low = ~r.mem[r.ptr][7];
                                    end else begin
                                        next_r.st = D_PTR;
                                    end
                                end
                                D_PTR: begin
                                    // out-of-map pointer values fold to location zero
                                    next_r.ptr = (r.sh > 8'(`RTCI_LOC_LAST)) ? 5'h00 :
                                        r.sh[4:0];
                                    next_r.hold = (r.sh > 8'(`RTCI_LOC_LAST)) ? 1'h1 :
                                        is_clk(r.sh[4:0]);
                                    next_r.st = D_WDATA;
                                end
                                D_WDATA: begin
                                    if (!is_rsv(r.ptr)) begin
                                        next_r.mem[r.ptr] = r.sh;
                                    end
                                    next_r.wr = 1'h1;
                                    next_r.wa = r.ptr;
                                    next_r.wd = r.sh;
                                    next_r.divrst = is_clk(r.ptr);
                                    next_r.ptr = next_loc(r.ptr);
                                    next_r.hold = is_clk(next_loc(r.ptr));
                                end
                                default: begin
                                    next_r.st = D_IDLE;
                                end
                            endcase
                        end else begin
                            next_r.bitn = 4'(r.bitn + 4'h1);
                        end
                    end
                end
                D_RDATA: begin
                    // master acknowledge is sampled in the ninth high phase
                    if (scl_rise && (r.bitn == 4'h8)) begin
                        next_r.mnak = sda_now;
                    end
                    if (scl_fall) begin
                        if (r.bitn < 4'h7) begin
                            next_r.bitn = 4'(r.bitn + 4'h1);
                            next_r.sh = {r.sh[6:0], 1'h0};
                            next_r.sda_low = ~r.sh[6];
                        end else if (r.bitn == 4'h7) begin
                            next_r.bitn = 4'h8;
                            next_r.sda_low = 1'h0;
                        end else begin
                            // acknowledge clock seen: step pointer whatever the answer
                            next_r.ptr = next_loc(r.ptr);
                            next_r.hold = is_clk(next_loc(r.ptr));
                            next_r.bitn = 4'h0;
                            if (r.mnak) begin
                                // line stays released until stop or a new start
                                next_r.st = D_IDLE;
                            end else begin
                                next_r.sh = r.mem[next_loc(r.ptr)];
                                next_r.sda_low = ~r.mem[next_loc(r.ptr)][7];
                            end
                        end
                    end
                end
                D_IDLE: begin
                    next_r.sda_low = 1'h0;
                end
                default: begin
                    next_r.st = D_IDLE;
                end
            endcase
        end
    end

    // state register; synchronisers reset to the idle-high bus level
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.st <= D_IDLE;
            r.scl_sy <= 3'h7;
            r.sda_sy <= 3'h7;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register
    assign bus.dev_sda_o = 1'h0;
    assign bus.dev_sda_oe = r.sda_low;
    assign reg_wr_o = r.wr;
    assign reg_addr_o = r.wa;
    assign reg_data_o = r.wd;
    assign hold_update_o = r.hold;
    assign div_reset_o = r.divrst;
    assign ptr_o = r.ptr;

endmodule // rtci_dev

// ==== rtl/rtci_host.sv ====
// Purpose: master end of the rtc two-wire port, with a write data buffer
// Assumes: one slave on the bus; scl made here by a quarter-period divider
// Notes: a stalled buffer holds scl low between bytes, which the bus allows
`timescale 1ns/100ps
`include "rtci_cfg.svh"

module rtci_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] rp;
        logic [AW-1:0] wp;
        logic [AW:0] cnt;
        logic full;
        logic has;
    } rtci_fifo_reg_type;

    rtci_fifo_reg_type r;
    rtci_fifo_reg_type next_r;
    logic push;
    logic pop;

    // index after p, for any depth
    function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
        return (p == AW'(D - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    assign push = in_valid_i & ~r.full;
    assign pop = out_ready_i & r.has;

    // flags are registered from the next count so the ports come from flops
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.mem[r.wp] = in_data_i;
            next_r.wp = inc(r.wp);
        end
        if (pop) begin
            next_r.rp = inc(r.rp);
        end
        next_r.cnt = (AW + 1)'(r.cnt + {AW'(0), push} - {AW'(0), pop});
        next_r.full = (next_r.cnt == (AW + 1)'(D));
        next_r.has = (next_r.cnt != '0);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign in_ready_o = ~r.full;
    assign out_valid_o = r.has;
    assign out_data_o = r.mem[r.rp];
endmodule // rtci_fifo

module rtci_host
    import rtci_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    rtci_bus_if.host bus,
    input wire logic cmd_valid_i,
    input wire rtci_op_type cmd_op_i,
    input wire logic [7:0] cmd_ptr_i,
    input wire logic [7:0] cmd_len_i,
    output logic cmd_ready_o,
    input wire logic wr_valid_i,
    input wire logic [7:0] wr_data_i,
    output logic wr_ready_o,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic done_o,
    output logic nack_o
);
    localparam logic [7:0] QTR = 8'(`RTCI_QTR_CYC - 1);

    typedef struct packed {
        logic [1:0] sda_sy;
        rtci_host_state_type st;
        rtci_stage_type stage;
        rtci_op_type op;
        logic [7:0] ptrb;
        logic [7:0] len;
        logic rs;
        logic [7:0] q;
        logic [1:0] ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic ackb;
        logic scl_low;
        logic sda_low;
        logic rdy;
        logic rdv;
        logic [7:0] rdd;
        logic done;
        logic nack;
    } rtci_host_reg_type;

    rtci_host_reg_type r;
    rtci_host_reg_type next_r;
    logic tick;
    logic f_valid;
    logic [7:0] f_data;
    logic f_ready;

    rtci_fifo #(.W(`RTCI_FIFO_WIDTH), .D(`RTCI_FIFO_DEPTH)) u_fifo (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(wr_valid_i),
        .in_data_i(wr_data_i),
        .in_ready_o(wr_ready_o),
        .out_valid_o(f_valid),
        .out_data_o(f_data),
        .out_ready_i(f_ready)
    );

    assign tick = (r.q == QTR);
    assign f_ready = (r.st == H_LOAD);

    // byte sequencer and bit timing; pins follow the next state
    always_comb begin
        next_r = r;
        next_r.sda_sy = {r.sda_sy[0], bus.sda};
        next_r.rdv = 1'h0;
        next_r.done = 1'h0;
        next_r.q = (r.st == H_IDLE || r.st == H_LOAD || tick) ? 8'h00 : 8'(r.q + 8'h01);
        if (r.st != H_IDLE && r.st != H_LOAD && tick) begin
            next_r.ph = 2'(r.ph + 2'h1);
            if (r.ph == 2'h2 && r.bitn < 4'h8 && r.st == H_RXB) begin
                next_r.sh = {r.sh[6:0], r.sda_sy[1]};
            end
            if (r.ph == 2'h2 && r.bitn == 4'h8 && r.st == H_TXB) begin
                next_r.ackb = r.sda_sy[1];
            end
        end
        case (r.st)
            H_IDLE: begin
                if (cmd_valid_i) begin
                    next_r.st = H_START;
                    next_r.op = cmd_op_i;
                    next_r.ptrb = cmd_ptr_i;
                    // a read of zero bytes still takes one
                    next_r.len = (cmd_op_i != OP_WRITE && cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
                    next_r.rs = 1'h0;
                    next_r.nack = 1'h0;
                    next_r.ph = 2'h0;
                end
            end
            H_START: begin
                if (tick && r.ph == 2'h3) begin
                    next_r.st = H_TXB;
                    next_r.bitn = 4'h0;
                    if (r.op == OP_READ_CUR || r.rs) begin
                        next_r.sh = `RTCI_ADDR_R;
                        next_r.stage = G_AR;
                    end else begin
                        next_r.sh = `RTCI_ADDR_W;
                        next_r.stage = G_AW;
                    end
                end
            end
            H_LOAD: begin
                if (f_valid) begin
                    next_r.st = H_TXB;
                    next_r.sh = f_data;
                    next_r.bitn = 4'h0;
                    next_r.ph = 2'h0;
                end
            end
            H_TXB: begin
                if (tick && r.ph == 2'h3) begin
                    if (r.bitn < 4'h8) begin
                        next_r.bitn = 4'(r.bitn + 4'h1);
                        next_r.sh = {r.sh[6:0], 1'h0};
                    end else if (r.ackb) begin
                        next_r.nack = 1'h1;
                        next_r.st = H_STOP;
                    end else begin
                        next_r.bitn = 4'h0;
                        case (r.stage)
                            G_AW: begin
                                next_r.sh = r.ptrb;
                                next_r.stage = G_PTR;
                            end
                            G_PTR: begin
                                next_r.stage = G_DATA;
                                next_r.rs = (r.op != OP_WRITE);
                                next_r.st = (r.op != OP_WRITE) ? H_START :
                                    (r.len == 8'h00) ? H_STOP : H_LOAD;
                            end
                            G_AR: begin
                                next_r.st = H_RXB;
                            end
                            default: begin
                                next_r.len = 8'(r.len - 8'h01);
                                next_r.st = (r.len == 8'h01) ? H_STOP : H_LOAD;
                            end
                        endcase
                    end
                end
            end
            H_RXB: begin
                if (tick && r.ph == 2'h3) begin
                    if (r.bitn < 4'h7) begin
                        next_r.bitn = 4'(r.bitn + 4'h1);
                    end else if (r.bitn == 4'h7) begin
                        // byte complete: hand it out and pick ack or nack
                        next_r.bitn = 4'h8;
                        next_r.rdv = 1'h1;
                        next_r.rdd = r.sh;
                        next_r.ackb = (r.len == 8'h01);
                    end else begin
                        next_r.bitn = 4'h0;
                        next_r.len = 8'(r.len - 8'h01);
                        next_r.st = (r.len == 8'h01) ? H_STOP : H_RXB;
                    end
                end
            end
            H_STOP: begin
                if (tick && r.ph == 2'h3) begin
                    next_r.st = H_IDLE;
                    next_r.done = 1'h1;
                end
            end
            default: begin
                next_r.st = H_IDLE;
            end
        endcase
        // pin pattern per phase: scl high in idle, in phases 1 and 2, and in 3 of a stop
        next_r.scl_low = !(next_r.st == H_IDLE || next_r.ph == 2'h1 || next_r.ph == 2'h2 ||
            (next_r.st == H_STOP && next_r.ph == 2'h3));
        case (next_r.st)
            H_START: next_r.sda_low = next_r.ph[1];
            H_STOP: next_r.sda_low = !next_r.ph[1];
            H_TXB: next_r.sda_low = (next_r.bitn < 4'h8) && !next_r.sh[7];
            H_RXB: next_r.sda_low = (next_r.bitn == 4'h8) && !next_r.ackb;
            default: next_r.sda_low = 1'h0;
        endcase
        next_r.rdy = (next_r.st == H_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '0;
            r.st <= H_IDLE;
            r.stage <= G_AW;
            r.sda_sy <= 2'h3;
            r.rdy <= 1'h1;
        end else begin
            r <= next_r;
        end
    end

    assign bus.host_scl_o = 1'h0;
    assign bus.host_scl_oe = r.scl_low;
    assign bus.host_sda_o = 1'h0;
    assign bus.host_sda_oe = r.sda_low;
    assign cmd_ready_o = r.rdy;
    assign rd_valid_o = r.rdv;
    assign rd_data_o = r.rdd;
    assign done_o = r.done;
    assign nack_o = r.nack;
endmodule // rtci_host

// ==== sim/rtci_bus_properties.sv ====
// Purpose: wire checks of the two-wire link
// Assumes: lines resolved by the bus interface
// Notes: bit count restarts at each start
`timescale 1ns/100ps
module rtci_bus_check (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    logic [7:0] nbit;
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // scl rises since start; 8 is the address ack pulse
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || ($fell(sda) && scl)) nbit <= 8'h00;
        else if ($rose(scl)) nbit <= nbit + 8'h01;
    end
    rst_idle_a: assert property ($fell(sys_rst_i) |-> (scl && sda) [*2])
        else $error("bus busy after reset");
    ack_steady_a: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
        else $error("slave sda moved in high phase");
    low_change_a: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
        else $error("slave sda moved near scl high");
    start_free_a: assert property ($fell(sda) && scl |-> !dev_sda_oe)
        else $error("slave drives at start");
    stop_quiet_a: assert property ($rose(sda) && scl |=> !dev_sda_oe [*8])
        else $error("slave drives after stop");
    addr_ack_a: assert property ($rose(scl) && nbit == 8'h08 |-> !sda)
        else $error("address not acked");
    addr_quiet_a: assert property ($rose(scl) && nbit < 8'h08 |-> !dev_sda_oe)
        else $error("slave drives in address");
    pulse_len_a: assert property ($rose(scl) |-> scl [*8])
        else $error("scl pulse too short");
    // repeated start, slave sending, stop
    cover property ($fell(sda) && scl && nbit > 8'h09);
    cover property ($rose(scl) && dev_sda_oe && nbit > 8'h09);
    cover property ($rose(sda) && scl);
endmodule // rtci_bus_check

// ==== sim/test_rtc_i2c_slave_register_port.sv ====
// Purpose: end-to-end test of both ends of the rtc port
// Assumes: one bus interface joins the ends
// Notes: a byte on the wire takes about 2300 cycles
`timescale 1ns/100ps
module test_rtc_i2c_slave_register_port;
    import rtci_pkg::*;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, cv = 1'b0, wv = 1'b0, rdy, wrdy, rv, dn, nk, rw, hd, dr;
    rtci_op_type op = OP_WRITE;
    logic [7:0] cp = 8'h00, cl = 8'h00, wd = 8'h00, rd, rgd, tdat = 8'h00;
    logic tw = 1'b0;
    logic [7:0] wdat[4] = '{8'hAA, 8'h55, 8'h66, 8'h77};
    logic [4:0] pt, rga, ta = 5'h00;
    int n_mismatch = 0, num_checks = 0, n_wr = 0, n_div = 0, n_hd = 0;
    logic [7:0] rq[$];
    rtci_bus_if i_rtci_bus_if();
    rtci_host i_rtci_host(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(i_rtci_bus_if),
        .cmd_valid_i(cv), .cmd_op_i(op), .cmd_ptr_i(cp), .cmd_len_i(cl), .cmd_ready_o(rdy),
        .wr_valid_i(wv), .wr_data_i(wd), .wr_ready_o(wrdy), .rd_valid_o(rv),
        .rd_data_o(rd), .done_o(dn), .nack_o(nk));
    rtci_dev i_rtci_dev(.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(i_rtci_bus_if),
        .tc_we_i(tw), .tc_addr_i(ta), .tc_data_i(tdat), .reg_wr_o(rw),
        .reg_addr_o(rga), .reg_data_o(rgd), .hold_update_o(hd), .div_reset_o(dr), .ptr_o(pt));
    rtci_bus_check i_rtci_bus_check(.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .dev_sda_oe(i_rtci_bus_if.dev_sda_oe), .scl(i_rtci_bus_if.scl), .sda(i_rtci_bus_if.sda));
    // tally of slave pulses and read bytes
    always @(posedge clk_i) begin
        if (rw === 1'b1) n_wr++;
        if (dr === 1'b1) n_div++;
        if (hd === 1'b1) n_hd++;
        if (rv === 1'b1) rq.push_back(rd);
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // callers are idle, so the command is taken at the first edge
    task automatic run(input rtci_op_type o, input logic [7:0] p, input logic [7:0] n);
        int k;
        op = o;
        cp = p;
        cl = n;
        cv = 1'b1;
        @(posedge clk_i) #1 cv = 1'b0;
        for (k = 0; dn !== 1'b1 && k < 40000; k++) @(posedge clk_i) #1;
        check("done", dn, 8'h01);
        check("nack", nk, 8'h00);
        check("ready", rdy, 8'h01);
    endtask
    // one-cycle user load of the time copy, once the hold is at level h
    task automatic user_load(input logic [4:0] a, input logic [7:0] v, input logic h);
        wait (hd === h);
        @(posedge clk_i) #1;
        tw = 1'b1;
        ta = a;
        tdat = v;
        @(posedge clk_i) #1 tw = 1'b0;
    endtask
    // buffer filled to refusal, then a write across the wrap
    task automatic t_write();
        for (int i = 0; i < 4; i++) begin
            wv = 1'b1;
            wd = wdat[i];
            @(posedge clk_i) #1;
        end
        wv = 1'b0;
        @(posedge clk_i) #1;
        check("full", wrdy, 8'h00);
        run(OP_WRITE, 8'h12, 8'h04);
        check("ptr", pt, 8'h02);
        check("writes", n_wr[7:0], 8'h04);
        check("divreset", n_div[7:0], 8'h02);
        check("addr", rga, 8'h01);
        check("data", rgd, 8'h77);
        check("held", 8'(n_hd > 0), 8'h01);
        check("hold", hd, 8'h00);
        $display("write test done");
    endtask
    // reserved byte reads zero; current read resumes after the wrap;
    // a user load is refused while held and taken once the stop lets go
    task automatic t_read();
        logic [7:0] ex[5] = '{8'h00, 8'h55, 8'h66, 8'h77, 8'hA5};
        rq.delete();
        run(OP_READ_PTR, 8'h12, 8'h02);
        fork
            run(OP_READ_CUR, 8'h00, 8'h02);
            user_load(5'h01, 8'hEE, 1'b1);
        join
        user_load(5'h02, 8'hA5, 1'b0);
        run(OP_READ_CUR, 8'h00, 8'h01);
        check("count", 8'(rq.size()), 8'h05);
        foreach (rq[i]) check("rd", rq[i], ex[i]);
        check("ptr", pt, 8'h03);
        check("hold", hd, 8'h00);
        $display("read test done");
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        #1 sys_rst_i = 1'b0;
        repeat (4) @(posedge clk_i) #1;
        t_write();
        t_read();
        complete_run();
    end
    // traffic takes about 39k cycles; this allows half as much again
    initial begin
        #600000;
        n_mismatch++;
        complete_run();
    end
endmodule // test_rtc_i2c_slave_register_port
